// *** bpo_pkg.sv ***
// Purpose: shared constants and types for the bridge ordering block
// Assumes: one-DWORD transactions, two directions (0 = down, 1 = up)
// Notes: command codes are the bus command nibbles
package bpo_pkg;
	// transaction field widths
	localparam int CMD_W = 4;
	localparam int ADDR_W = 32;
	localparam int DATA_W = 32;
	localparam int BE_W = 4;
	localparam int XACT_W = CMD_W + ADDR_W + DATA_W + BE_W;
	// default queue sizes
	localparam int PW_DEPTH = 4;
	localparam int DT_DEPTH = 2;
	// posted write sequence counter width
	localparam int CNT_W = 8;
	// values after reset
	localparam logic [CNT_W-1:0] CNT_RST = 8'h00;
	localparam logic ARB_PREF_RST = 1'b0;
	// bus commands
	localparam logic [CMD_W-1:0] CMD_IO_RD = 4'h2;
	localparam logic [CMD_W-1:0] CMD_IO_WR = 4'h3;
	localparam logic [CMD_W-1:0] CMD_MEM_RD = 4'h6;
	localparam logic [CMD_W-1:0] CMD_MEM_WR = 4'h7;
	localparam logic [CMD_W-1:0] CMD_CFG_RD = 4'hA;
	localparam logic [CMD_W-1:0] CMD_CFG_WR = 4'hB;
	localparam logic [CMD_W-1:0] CMD_MEM_RDMUL = 4'hC;
	localparam logic [CMD_W-1:0] CMD_MEM_RDLINE = 4'hE;
	localparam logic [CMD_W-1:0] CMD_MEM_WRINV = 4'hF;
	// delayed transaction entry states
	typedef enum logic [3:0] {
		BPO_FREE = 4'h1,
		BPO_PEND = 4'h2,
		BPO_BUSY = 4'h4,
		BPO_DONE = 4'h8
	} bpo_ent_type;
endpackage

// *** bpo_stream_if.sv ***
// Purpose: valid/ready stream between the block's own modules
// Assumes: transfer when valid and ready are both high at a clock edge
// Notes: src drives data, snk drives ready
interface bpo_stream_if #(parameter int WIDTH = 8) ();
	logic valid; // word offered
	logic ready; // word accepted
	logic [WIDTH-1:0] data; // the word
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface

// *** bpo_fifo.sv ***
// Purpose: posted write buffer, one whole transaction per entry
// Assumes: DEPTH of two or more
// Notes: ready is low when full, valid is low when empty
module bpo_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_b,
	// filling and draining sides
	bpo_stream_if.snk push,
	bpo_stream_if.src pop
);
	localparam int PTR_W = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH]; // storage
	logic [PTR_W-1:0] wr_ptr; // next slot to fill
	logic [PTR_W-1:0] rd_ptr; // oldest slot
	logic [PTR_W:0] fill; // words held
	logic do_push;
	logic do_pop;
	logic [PTR_W-1:0] next_wr_ptr;
	logic [PTR_W-1:0] next_rd_ptr;

	// handshakes and flags
	assign do_push = push.valid & push.ready;
	assign do_pop = pop.valid & pop.ready;
	assign push.ready = (fill != (PTR_W + 1)'(DEPTH));
	assign pop.valid = (fill != '0);
	assign pop.data = mem[rd_ptr];
	assign next_wr_ptr = (wr_ptr == PTR_W'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
	assign next_rd_ptr = (rd_ptr == PTR_W'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;

	// storage write, no reset needed
	always_ff @(posedge core_clk) begin
		if (do_push) begin
			mem[wr_ptr] <= push.data;
		end
	end

	// pointers and fill level
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			fill <= '0;
		end else begin
			if (do_push) begin
				wr_ptr <= next_wr_ptr;
			end
			if (do_pop) begin
				rd_ptr <= next_rd_ptr;
			end
			fill <= fill + (PTR_W + 1)'(do_push) - (PTR_W + 1)'(do_pop);
		end
	end
endmodule

// *** bpo_arb.sv ***
// Purpose: fair choice between posted queue and delayed queue
// Assumes: a grant is used when taken is high in the same cycle
// Notes: the loser of a contested grant wins the next contest
module bpo_arb (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_b,
	// requests
	input wire logic req_post,
	input wire logic req_dly,
	input wire logic taken,
	// grants
	output logic grant_post,
	output logic grant_dly
);
	logic pref_dly; // delayed queue wins the next tie

	// grant decode
	assign grant_post = req_post & (~req_dly | ~pref_dly);
	assign grant_dly = req_dly & (~req_post | pref_dly);

	// rotate preference after each transfer
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			pref_dly <= bpo_pkg::ARB_PREF_RST;
		end else if (taken) begin
			pref_dly <= grant_post;
		end
	end
endmodule

// *** bpo_bridge_order.sv ***
// Purpose: classify, queue and order transactions crossing the bridge
// Assumes: one request per direction per cycle, one DWORD each
// Notes: index 0 runs primary to secondary, index 1 the other way
module bpo_bridge_order #(
	parameter int PW_DEPTH = bpo_pkg::PW_DEPTH,
	parameter int DT_DEPTH = bpo_pkg::DT_DEPTH
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_b,
	// initiator bus side, one lane per direction
	input wire logic [1:0] req_valid,
	input wire logic [1:0][bpo_pkg::CMD_W-1:0] req_cmd,
	input wire logic [1:0][bpo_pkg::ADDR_W-1:0] req_addr,
	input wire logic [1:0][bpo_pkg::DATA_W-1:0] req_data,
	input wire logic [1:0][bpo_pkg::BE_W-1:0] req_be,
	// initiator bus answers, one cycle after the request
	output wire logic [1:0] req_ack,
	output wire logic [1:0] req_retry,
	output wire logic [1:0][bpo_pkg::DATA_W-1:0] req_rdata,
	// target bus side, transaction to issue
	output wire logic [1:0] mst_valid,
	output wire logic [1:0][bpo_pkg::CMD_W-1:0] mst_cmd,
	output wire logic [1:0][bpo_pkg::ADDR_W-1:0] mst_addr,
	output wire logic [1:0][bpo_pkg::DATA_W-1:0] mst_data,
	output wire logic [1:0][bpo_pkg::BE_W-1:0] mst_be,
	output wire logic [1:0] mst_posted,
	output wire logic [1:0][$clog2(DT_DEPTH)-1:0] mst_tag,
	input wire logic [1:0] mst_ready,
	// target bus side, delayed transaction finished
	input wire logic [1:0] mst_done,
	input wire logic [1:0][$clog2(DT_DEPTH)-1:0] mst_done_tag,
	input wire logic [1:0][bpo_pkg::DATA_W-1:0] mst_done_rdata
);
	// widths derived from the package and the table depth
	localparam int IDX_W = $clog2(DT_DEPTH);
	localparam int XW = bpo_pkg::XACT_W;
	localparam int CW = bpo_pkg::CNT_W;

	// running counts of posted writes, shared between the two directions
	// so that a completion can wait on the opposite lane's buffer
	wire [1:0][CW-1:0] push_seen; // posted writes accepted, per direction
	wire [1:0][CW-1:0] pop_seen; // posted writes issued, per direction

	// true once every posted write counted in mark has left
	// counts wrap, so the test is on the sign of the difference;
	// this holds while fewer than half the counter range is in flight,
	// far more than the posted buffer can ever hold
	function automatic logic caught(input logic [CW-1:0] pop, input logic [CW-1:0] mark);
		logic [CW-1:0] gap;
		gap = pop - mark;
		// clear sign bit: pop has reached mark
		return ~gap[CW-1];
	endfunction

	// one complete ordering engine per direction
	// each lane owns its posted buffer, delayed table and arbiter, so
	// writes in opposite directions never wait on each other;
	// the only cross-lane link is the opposite lane's posted counts,
	// read when a completion is returned
	for (genvar d = 0; d < 2; d++) begin : g_dir
		localparam int O = 1 - d;

		// per-lane decode and table search results
		logic [XW-1:0] req_x; // incoming transaction, packed
		logic [XW-1:0] req_key; // match key, data ignored for reads
		logic is_post; // memory write or write-and-invalidate
		logic is_dwr; // I/O or configuration write
		logic is_drd; // any read
		logic is_dly; // any delayed class
		logic hit; // same request already queued
		logic [IDX_W-1:0] hit_idx;
		logic free_ok; // an entry is free
		logic [IDX_W-1:0] free_idx;
		logic iss_ok; // an entry may go to the target bus
		logic [IDX_W-1:0] iss_idx;
		logic deliver; // completion handed back now
		logic grant_post;
		logic grant_dly;
		logic take; // target bus engine accepted the offer
		logic [XW-1:0] mst_x;
		logic [CW-1:0] push_cnt;
		logic [CW-1:0] pop_cnt;
		logic ack;
		logic retry;
		logic [bpo_pkg::DATA_W-1:0] rdata;
		// delayed transaction rows, one per outstanding request
		// only the state and clear flag are reset; key and data are read only once
		// the state says they were written
		bpo_pkg::bpo_ent_type ent_st [DT_DEPTH]; // entry state
		logic [XW-1:0] ent_key [DT_DEPTH]; // queued request
		logic [CW-1:0] ent_mark [DT_DEPTH]; // posted writes ahead of it
		logic ent_clr [DT_DEPTH]; // those writes have all left
		logic [bpo_pkg::DATA_W-1:0] ent_rdata [DT_DEPTH]; // completion data

		// streams into and out of the posted buffer
		bpo_stream_if #(.WIDTH(XW)) pw_in ();
		bpo_stream_if #(.WIDTH(XW)) pw_out ();

		// command decode
		// unlisted commands fall in no class and get no answer
		assign req_x = {req_cmd[d], req_addr[d], req_data[d], req_be[d]};
		assign is_post = (req_cmd[d] == bpo_pkg::CMD_MEM_WR) ||
			(req_cmd[d] == bpo_pkg::CMD_MEM_WRINV);
		assign is_dwr = (req_cmd[d] == bpo_pkg::CMD_IO_WR) ||
			(req_cmd[d] == bpo_pkg::CMD_CFG_WR);
		assign is_drd = (req_cmd[d] == bpo_pkg::CMD_IO_RD) ||
			(req_cmd[d] == bpo_pkg::CMD_CFG_RD) ||
			(req_cmd[d] == bpo_pkg::CMD_MEM_RD) ||
			(req_cmd[d] == bpo_pkg::CMD_MEM_RDMUL) ||
			(req_cmd[d] == bpo_pkg::CMD_MEM_RDLINE);
		assign is_dly = is_dwr | is_drd;
		// reads match on command, address and enables only, since their
		// data phase carries nothing; writes must match in full
		assign req_key = is_dwr ? req_x :
			{req_cmd[d], req_addr[d], {bpo_pkg::DATA_W{1'b0}}, req_be[d]};

		// posted path: each write is its own entry, never merged
		// a full buffer answers retry and stores nothing, so no two
		// writes ever share an entry
		assign pw_in.valid = req_valid[d] & is_post;
		assign pw_in.data = req_x;
		// pop only when the buffer was chosen and the far side took it
		assign pw_out.ready = mst_ready[d] & grant_post;

		// in-order posted write buffer
		bpo_fifo #(.WIDTH(XW), .DEPTH(PW_DEPTH)) u_pw (
			.core_clk(core_clk),
			.rst_b(rst_b),
			.push(pw_in),
			.pop(pw_out)
		);

		// table search: match, free slot, issue candidate
		// scan from the top so that the lowest matching index wins;
		// a request matches at most one row, as a repeat never allocates
		always_comb begin
			hit = 1'b0;
			hit_idx = '0;
			free_ok = 1'b0;
			free_idx = '0;
			iss_ok = 1'b0;
			iss_idx = '0;
			for (int i = DT_DEPTH - 1; i >= 0; i--) begin
				// a repeat of a queued request
				if (ent_st[i] != bpo_pkg::BPO_FREE && ent_key[i] == req_key) begin
					hit = 1'b1;
					hit_idx = IDX_W'(i);
				end
				// any free row can take a new request
				if (ent_st[i] == bpo_pkg::BPO_FREE) begin
					free_ok = 1'b1;
					free_idx = IDX_W'(i);
				end
				// lowest ready entry, no order among delayed ones
				if (ent_st[i] == bpo_pkg::BPO_PEND && ent_clr[i]) begin
					iss_ok = 1'b1;
					iss_idx = IDX_W'(i);
				end
			end
		end

		// completion returns on repeat; reads wait for opposite posted writes
		// write completions carry no data and may pass posted writes,
		// so only read completions wait on the opposite buffer
		assign deliver = req_valid[d] & is_dly & hit &
			(ent_st[hit_idx] == bpo_pkg::BPO_DONE) &
			(is_dwr | ent_clr[hit_idx]);

		// fair choice between the two queues
		// the loser of a contested cycle wins the next one, so posted
		// writes always get a turn past waiting delayed traffic
		bpo_arb u_arb (
			.core_clk(core_clk),
			.rst_b(rst_b),
			.req_post(pw_out.valid),
			.req_dly(iss_ok),
			.taken(take),
			.grant_post(grant_post),
			.grant_dly(grant_dly)
		);

		// target bus offer
		// a plain mux of stored words; it may change from cycle to
		// cycle until the far engine takes it
		assign take = mst_ready[d] & (grant_post | grant_dly);
		assign mst_x = grant_post ? pw_out.data : ent_key[iss_idx];
		assign mst_valid[d] = grant_post | grant_dly;
		assign {mst_cmd[d], mst_addr[d], mst_data[d], mst_be[d]} = mst_x;
		assign mst_posted[d] = grant_post;
		// the tag only means something for delayed offers
		assign mst_tag[d] = iss_idx;

		// answer toward the initiator, one cycle later
		// exactly one of ack and retry for every classified request
		always_ff @(posedge core_clk) begin
			if (!rst_b) begin
				ack <= 1'b0;
				retry <= 1'b0;
				rdata <= '0;
			end else begin
				// posted acceptance looks only at buffer room
				ack <= (pw_in.valid & pw_in.ready) | deliver;
				// full buffer, or a delayed request not yet complete
				retry <= (pw_in.valid & ~pw_in.ready) |
					(req_valid[d] & is_dly & ~deliver);
				if (deliver) begin
					rdata <= ent_rdata[hit_idx];
				end
			end
		end
		// registered answers onto the lane ports
		assign req_ack[d] = ack;
		assign req_retry[d] = retry;
		assign req_rdata[d] = rdata;

		// posted write sequence counters
		// push counts mark how many writes a new entry must wait for,
		// pop counts show how many of them have left
		always_ff @(posedge core_clk) begin
			if (!rst_b) begin
				push_cnt <= bpo_pkg::CNT_RST;
				pop_cnt <= bpo_pkg::CNT_RST;
			end else begin
				// a write entered the buffer
				if (pw_in.valid & pw_in.ready) begin
					push_cnt <= push_cnt + 1'b1;
				end
				// a write left for the far bus
				if (pw_out.valid & pw_out.ready) begin
					pop_cnt <= pop_cnt + 1'b1;
				end
			end
		end
		// export counts for the opposite lane
		assign push_seen[d] = push_cnt;
		assign pop_seen[d] = pop_cnt;

		// delayed transaction table
		// a row moves free, pending, busy on the far bus, done, free;
		// each state change below starts from a different row state, so no
		// two of them in one cycle ever land on the same row
		always_ff @(posedge core_clk) begin
			if (!rst_b) begin
				for (int i = 0; i < DT_DEPTH; i++) begin
					ent_st[i] <= bpo_pkg::BPO_FREE;
					ent_clr[i] <= 1'b0;
				end
			end else begin
				// latch when the posted writes ahead have drained
				// the latch costs one cycle but keeps the wide compare
				// off the offer path
				for (int i = 0; i < DT_DEPTH; i++) begin
					if (ent_st[i] == bpo_pkg::BPO_PEND) begin
						ent_clr[i] <= ent_clr[i] | caught(pop_seen[d], ent_mark[i]);
					end else if (ent_st[i] == bpo_pkg::BPO_DONE) begin
						ent_clr[i] <= ent_clr[i] | caught(pop_seen[O], ent_mark[i]);
					end
				end
				// new request: queue it behind posted writes already held
				// a full table answers retry and stores nothing
				if (req_valid[d] & is_dly & ~hit & free_ok) begin
					ent_st[free_idx] <= bpo_pkg::BPO_PEND;
					ent_key[free_idx] <= req_key;
					ent_mark[free_idx] <= push_seen[d];
					ent_clr[free_idx] <= 1'b0;
				end
				// completion handed back frees the entry
				// repeats after this allocate afresh
				if (deliver) begin
					ent_st[hit_idx] <= bpo_pkg::BPO_FREE;
				end
				// issued to the target bus
				// the row stays busy until the far engine reports it done
				if (take & grant_dly) begin
					ent_st[iss_idx] <= bpo_pkg::BPO_BUSY;
				end
				// finished on target bus: order is fixed here
				// a done for a row that is not busy is ignored;
				// a read completion now waits for the opposite lane's writes
				if (mst_done[d] && ent_st[mst_done_tag[d]] == bpo_pkg::BPO_BUSY) begin
					ent_st[mst_done_tag[d]] <= bpo_pkg::BPO_DONE;
					ent_rdata[mst_done_tag[d]] <= mst_done_rdata[d];
					ent_mark[mst_done_tag[d]] <= push_seen[O];
					ent_clr[mst_done_tag[d]] <= 1'b0;
				end
			end
		end
	end
endmodule

// *** bpo_bridge_order_properties.sv ***
// Purpose: port-level checks for the ordering block
// Assumes: one clock, synchronous active-low reset
// Notes: the held-write count watches lane 0 only
module bpo_order_checker #(
	parameter int PW_DEPTH = 4,
	parameter int DT_DEPTH = 2
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_b,
	// initiator side
	input wire logic [1:0] req_valid,
	input wire logic [1:0][bpo_pkg::CMD_W-1:0] req_cmd,
	input wire logic [1:0] req_ack,
	input wire logic [1:0] req_retry,
	// target side
	input wire logic [1:0] mst_valid,
	input wire logic [1:0][bpo_pkg::CMD_W-1:0] mst_cmd,
	input wire logic [1:0][bpo_pkg::DATA_W-1:0] mst_data,
	input wire logic [1:0] mst_posted,
	input wire logic [1:0] mst_ready
);
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_b);
	logic post_q; // lane 0 posted request last cycle
	logic [7:0] pw_cnt; // lane 0 posted writes still held
	// command classes
	wire is_post0 = req_valid[0] && (req_cmd[0] inside {4'h7, 4'hF});
	wire known0 = req_valid[0] && (req_cmd[0] inside {4'h2, 4'h3, 4'h6, 4'h7, 4'hA, 4'hB, 4'hC, 4'hE, 4'hF});
	wire rd_off0 = mst_valid[0] && !mst_posted[0] && (mst_cmd[0] inside {4'h2, 4'h6, 4'hA, 4'hC, 4'hE});
	wire pop0 = mst_valid[0] && mst_ready[0] && mst_posted[0];
	// count accepted writes not yet issued
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			post_q <= 1'b0;
			pw_cnt <= 8'h00;
		end else begin
			post_q <= is_post0;
			pw_cnt <= pw_cnt + 8'(req_ack[0] && post_q) - 8'(pop0);
		end
	end
	sequence s_post_room; is_post0 && pw_cnt < 8'(PW_DEPTH - 1); endsequence
	property p_post_accept; s_post_room |=> req_ack[0]; endproperty
	a_post_accept: assert property (p_post_accept) else $error("posted write refused");
	property p_classified; known0 |=> req_ack[0] ^ req_retry[0]; endproperty
	a_classified: assert property (p_classified) else $error("not answered once");
	property p_unlisted; req_valid[0] && !known0 |=> !req_ack[0] && !req_retry[0]; endproperty
	a_unlisted: assert property (p_unlisted) else $error("unknown command answered");
	property p_cause; req_ack[0] || req_retry[0] |-> $past(req_valid[0]); endproperty
	a_cause: assert property (p_cause) else $error("answer without request");
	property p_excl; $onehot0({req_ack[1], req_retry[1]}); endproperty
	a_excl: assert property (p_excl) else $error("ack with retry");
	property p_posted_cmd; mst_valid[0] && mst_posted[0] |-> mst_cmd[0] inside {4'h7, 4'hF}; endproperty
	a_posted_cmd: assert property (p_posted_cmd) else $error("non-write posted");
	property p_dly_cmd; mst_valid[1] && !mst_posted[1] |-> !(mst_cmd[1] inside {4'h7, 4'hF}); endproperty
	a_dly_cmd: assert property (p_dly_cmd) else $error("memory write delayed");
	property p_rd_data; rd_off0 |-> mst_data[0] == 32'h0000_0000; endproperty
	a_rd_data: assert property (p_rd_data) else $error("read offered with data");
endmodule
bind bpo_bridge_order bpo_order_checker #(.PW_DEPTH(PW_DEPTH), .DT_DEPTH(DT_DEPTH)) bpo_order_checker_inst (
	.core_clk(core_clk), .rst_b(rst_b), .req_valid(req_valid), .req_cmd(req_cmd), .req_ack(req_ack),
	.req_retry(req_retry), .mst_valid(mst_valid), .mst_cmd(mst_cmd), .mst_data(mst_data),
	.mst_posted(mst_posted), .mst_ready(mst_ready));

// *** bpo_target_model.sv ***
// Purpose: far-bus target engine on both lanes
// Assumes: offers taken at the rising edge, answers driven at the falling edge
// Notes: read data is the address xor a fixed mask
module bpo_target_model (
	// clock and test controls
	input wire logic core_clk,
	input wire logic [1:0] stall,
	input wire logic [7:0] lat,
	// offers from the block
	input wire logic [1:0] mst_valid,
	input wire logic [1:0][31:0] mst_addr,
	input wire logic [1:0] mst_posted,
	input wire logic [1:0][0:0] mst_tag,
	// answers to the block
	output logic [1:0] mst_ready = 2'b00,
	output logic [1:0] mst_done = 2'b00,
	output logic [1:0][0:0] mst_done_tag = '0,
	output logic [1:0][31:0] mst_done_rdata = '0
);
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [31:0] RD_MASK = 32'h5A5A_0000; // returned read pattern
	logic [1:0] busy = 2'b00; // delayed item in flight
	logic [1:0] stall_q = 2'b00; // stall as seen at the last rising edge
	logic [1:0][31:0] held_addr; // its address
	logic [1:0][0:0] held_tag; // its table index
	int wait_c [2]; // cycles left before its answer
	// take a delayed item and start its latency
	always @(posedge core_clk) begin
		stall_q = stall;
		for (int d = 0; d < 2; d++) begin
			if (mst_valid[d] && mst_ready[d] && !mst_posted[d]) begin
				held_addr[d] = mst_addr[d];
				held_tag[d] = mst_tag[d];
				busy[d] = 1'b1;
				wait_c[d] = lat;
			end
		end
	end
	// ready and done, off the sampling edge
	always @(negedge core_clk) begin
		for (int d = 0; d < 2; d++) begin
			// only delayed offers wait while one is in flight
			mst_ready[d] <= !stall_q[d] && !(busy[d] && mst_posted[d] !== 1'b1);
			mst_done[d] <= busy[d] && wait_c[d] == 0;
			if (busy[d] && wait_c[d] == 0) begin
				mst_done_tag[d] <= held_tag[d];
				mst_done_rdata[d] <= held_addr[d] ^ RD_MASK;
				busy[d] = 1'b0;
			end else begin
				mst_done_rdata[d] <= ~mst_done_rdata[d]; // released lines
				wait_c[d] = wait_c[d] - 1;
			end
		end
	end
endmodule

// *** pci_bridge_transaction_ordering_tb_top.sv ***
// Purpose: self-checking bench for the ordering block
// Assumes: inputs change at the falling edge
// Notes: taken items logged as {posted, be, addr}
module pci_bridge_transaction_ordering_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [31:0] RD_MASK = 32'h5A5A_0000; // model read pattern
	logic core_clk = 1'b0;
	logic rst_b = 1'b0;
	logic [1:0] req_valid = 2'b00;
	logic [1:0][3:0] req_cmd = '0, req_be = '0, mst_cmd, mst_be;
	logic [1:0][31:0] req_addr = '0, req_data = '0, req_rdata, mst_addr, mst_data, mst_done_rdata;
	logic [1:0] req_ack, req_retry, mst_valid, mst_posted, mst_ready, mst_done;
	logic [1:0][0:0] mst_tag, mst_done_tag;
	logic [1:0] stall = 2'b00; // far engine stall per lane
	logic [7:0] lat = 8'h00; // far engine latency
	logic [36:0] tlog [2][$]; // items taken per lane
	int num_errors = 0, checks_done = 0, cycles = 0;
	int data_bad = 0; // taken items whose data broke the rules
	bpo_bridge_order bpo_bridge_order_inst (.*);
	bpo_target_model bpo_target_model_inst (.*);
	// clock
	initial begin
		forever #10 core_clk = ~core_clk;
	end
	// log taken items, cut a hang short
	always @(posedge core_clk) begin
		for (int d = 0; d < 2; d++) begin
			if (mst_valid[d] === 1'b1 && mst_ready[d] === 1'b1) begin
				tlog[d].push_back({mst_posted[d], mst_be[d], mst_addr[d]});
				// writes (low command bit set) carry the driven data, reads none
				if (mst_data[d] !== ((mst_posted[d] || mst_cmd[d][0]) ?
					~mst_addr[d] : 32'h0000_0000)) begin
					data_bad++;
				end
			end
		end
		cycles++;
		if (cycles == 20000) begin
			num_errors++;
			conclude();
		end
	end
	task automatic check(input logic [36:0] seen, input logic [36:0] exp);
		checks_done++;
		if (seen !== exp) begin
			num_errors++;
			$display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// one request, answer seen the next cycle
	task automatic xfer(input int d, input logic [3:0] cmd, input logic [31:0] addr,
		input logic [3:0] be, output logic a, output logic r);
		@(negedge core_clk);
		req_valid[d] = 1'b1;
		req_cmd[d] = cmd;
		req_addr[d] = addr;
		req_data[d] = ~addr;
		req_be[d] = be;
		@(negedge core_clk);
		req_valid[d] = 1'b0;
		a = req_ack[d];
		r = req_retry[d];
	endtask
	// repeat a delayed request until it completes
	task automatic until_ack(input int d, input logic [3:0] cmd, input logic [31:0] addr,
		output logic [31:0] rd);
		logic a;
		logic r;
		a = 1'b0;
		for (int n = 0; n < 60 && a !== 1'b1; n++) begin
			xfer(d, cmd, addr, 4'hF, a, r);
		end
		check(a, 1'b1);
		rd = req_rdata[d];
	endtask
	task automatic wait_log(input int d, input int cnt);
		for (int n = 0; n < 80 && tlog[d].size() < cnt; n++) begin
			@(negedge core_clk);
		end
	endtask
	// fill lane 0 posted buffer with masked writes to one DWORD
	task automatic t_fill();
		logic a;
		logic r;
		stall = 2'b01;
		for (int i = 0; i < 5; i++) begin
			xfer(0, i[0] ? bpo_pkg::CMD_MEM_WRINV : bpo_pkg::CMD_MEM_WR, 32'h100, 4'h1 << i[1:0], a, r);
			check({a, r}, (i < 4) ? 2'b10 : 2'b01);
		end
		stall = 2'b00;
		wait_log(0, 4);
		for (int i = 0; i < 4; i++) begin
			check(tlog[0][i], {1'b1, 4'h1 << i, 32'h100});
		end
		check(tlog[0].size(), 4);
		tlog[0].delete();
	endtask
	// every read command, behind a held write
	task automatic t_reads();
		logic [3:0] cmds [5] = '{bpo_pkg::CMD_IO_RD, bpo_pkg::CMD_MEM_RD, bpo_pkg::CMD_CFG_RD,
			bpo_pkg::CMD_MEM_RDMUL, bpo_pkg::CMD_MEM_RDLINE};
		logic a;
		logic r;
		logic [31:0] rd;
		int pos;
		for (int i = 0; i < 5; i++) begin
			stall[i % 2] = 1'b1;
			lat = 8'(i * 5);
			xfer(i % 2, bpo_pkg::CMD_MEM_WR, 32'h2000, 4'hF, a, r);
			xfer(i % 2, cmds[i], 32'h3000 + i, 4'hF, a, r);
			check(r, 1'b1);
			xfer(i % 2, bpo_pkg::CMD_MEM_WR, 32'h2004, 4'hF, a, r);
			check(a, 1'b1);
			stall[i % 2] = 1'b0;
			until_ack(i % 2, cmds[i], 32'h3000 + i, rd);
			check(rd, (32'h3000 + i) ^ RD_MASK);
			pos = 0;
			for (int j = 0; j < tlog[i % 2].size(); j++) begin
				pos = (tlog[i % 2][j][36] === 1'b0) ? j : pos;
			end
			check(tlog[i % 2][0], {1'b1, 4'hF, 32'h2000});
			check(tlog[i % 2][pos], {1'b0, 4'hF, 32'h3000 + i});
			tlog[i % 2].delete();
		end
	endtask
	// delayed writes behind a held write, and an unknown command
	task automatic t_writes();
		logic a;
		logic r;
		logic [31:0] rd;
		xfer(0, 4'h0, 32'h0, 4'hF, a, r);
		check({a, r}, 2'b00);
		for (int i = 0; i < 2; i++) begin
			stall = 2'b01;
			xfer(0, bpo_pkg::CMD_MEM_WR, 32'h4000, 4'hF, a, r);
			xfer(0, i ? bpo_pkg::CMD_CFG_WR : bpo_pkg::CMD_IO_WR, 32'h5000, 4'hF, a, r);
			check(r, 1'b1);
			stall = 2'b00;
			until_ack(0, i ? bpo_pkg::CMD_CFG_WR : bpo_pkg::CMD_IO_WR, 32'h5000, rd);
			check(tlog[0][1], {1'b0, 4'hF, 32'h5000});
			tlog[0].delete();
		end
	endtask
	// read completion held behind a write in the opposite lane
	task automatic t_opposite();
		logic a;
		logic r;
		logic [31:0] rd;
		stall = 2'b10;
		lat = 8'h00;
		xfer(1, bpo_pkg::CMD_MEM_WR, 32'h6000, 4'hF, a, r);
		xfer(0, bpo_pkg::CMD_MEM_RD, 32'h7000, 4'hF, a, r);
		wait_log(0, 1);
		repeat (4) @(negedge core_clk);
		xfer(0, bpo_pkg::CMD_MEM_RD, 32'h7000, 4'hF, a, r);
		check(r, 1'b1);
		xfer(0, bpo_pkg::CMD_MEM_WR, 32'h7100, 4'hF, a, r);
		check(a, 1'b1);
		stall = 2'b00;
		until_ack(0, bpo_pkg::CMD_MEM_RD, 32'h7000, rd);
		check(rd, 32'h7000 ^ RD_MASK);
		check(tlog[1][0], {1'b1, 4'hF, 32'h6000});
		check(data_bad, 0);
	endtask
	task automatic conclude();
		$display("errors=%0d checks=%0d", num_errors, checks_done);
		if (num_errors == 0 && checks_done > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	// main sequence
	initial begin
		repeat (2) @(negedge core_clk);
		rst_b = 1'b1;
		t_fill();
		t_reads();
		t_writes();
		t_opposite();
		conclude();
	end
endmodule
